// ===== sdbt_pkg.sv
// Package: shared constants and types for the SDRAM burst/precharge/power-down link.
// Assumes both ends run on one 10 MHz clock ref_clk.
package sdbt_pkg;
	localparam int sdbt_bank_bits = 2;
	localparam int sdbt_nbanks = 4;
	localparam int sdbt_col_bits = 8;
	localparam int sdbt_addr_bits = 11;
	localparam int sdbt_data_bits = 32;
	localparam int sdbt_all_bank_pos = 10;
	localparam logic [2:0] sdbt_burst_full = 3'h7;
	localparam int sdbt_clk_ns = 100;
	localparam int sdbt_prech_ns = 20;
	localparam int sdbt_wrec_ns = 14;
	localparam int sdbt_prech_cyc = (sdbt_prech_ns + sdbt_clk_ns - 1) / sdbt_clk_ns;
	localparam int sdbt_wrec_cyc = (sdbt_wrec_ns + sdbt_clk_ns - 1) / sdbt_clk_ns;
	localparam int sdbt_pdn_max_ms = 64;
	localparam int sdbt_pdn_max_cyc = sdbt_pdn_max_ms * 10000;
	// Command pattern {row, col, we} with chip select low
	localparam logic [2:0] sdbt_cmd_read = 3'h5;
	localparam logic [2:0] sdbt_cmd_write = 3'h4;
	localparam logic [2:0] sdbt_cmd_prech = 3'h2;
	localparam logic [2:0] sdbt_cmd_bterm = 3'h6;
	localparam logic [2:0] sdbt_cmd_nop = 3'h7;
	localparam logic [2:0] sdbt_cmd_active = 3'h3;
	typedef enum logic [1:0] {sdbt_idle, sdbt_row_active, sdbt_reading, sdbt_writing} sdbt_bank_type;
endpackage : sdbt_pkg

// ===== sdbt_if.sv
// Interface: pins between the memory controller and the DRAM device.
// Assumes the testbench resolves dq from the two enables.
`timescale 1ns/1ps
interface sdbt_if import sdbt_pkg::*; (input wire logic ref_clk);
	logic cke;
	logic cs_n;
	logic row_strobe_n;
	logic col_strobe_n;
	logic wr_en_n;
	logic [sdbt_addr_bits-1:0] addr;
	logic [sdbt_bank_bits-1:0] bank;
	logic dqm;
	logic [sdbt_data_bits-1:0] dq_ctl_out;
	logic dq_ctl_oe;
	logic [sdbt_data_bits-1:0] dq_dev_out;
	logic dq_dev_oe;
	logic [sdbt_data_bits-1:0] dq_in;
	modport device (input ref_clk, cke, cs_n, row_strobe_n, col_strobe_n, wr_en_n, addr, bank, dqm, dq_in,
		output dq_dev_out, dq_dev_oe);
	modport ctrl (input ref_clk, dq_in, output cke, cs_n, row_strobe_n, col_strobe_n, wr_en_n, addr, bank,
		dqm, dq_ctl_out, dq_ctl_oe);
endinterface : sdbt_if

// ===== sdbt_device.sv
// Device end: command decode, bank tracking, write bursts, read drive, suspend, power-down.
// Assumes the controller keeps its own timing; pins are synchronous to ref_clk (same-domain logic).
`timescale 1ns/1ps
module sdbt_device import sdbt_pkg::*; (
	input wire logic rst_n,
	sdbt_if.device pins,
	input wire logic [2:0] burst_len_code,
	input wire logic write_burst_mode_bit,
	input wire logic [1:0] read_latency_cycles,
	input wire logic [sdbt_data_bits-1:0] rd_data,
	output logic wr_valid,
	output logic [sdbt_bank_bits-1:0] wr_bank,
	output logic [sdbt_col_bits-1:0] wr_col,
	output logic [sdbt_data_bits-1:0] wr_data,
	output logic power_down,
	output logic precharge_power_down,
	output logic clock_suspended,
	output logic [2*sdbt_nbanks-1:0] bank_states
);
	wire logic clk = pins.ref_clk;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic [2:0] pattern;
	logic cmd_sel;
	logic cke_prev;
	logic susp;
	assign pattern = {pins.row_strobe_n, pins.col_strobe_n, pins.wr_en_n};
	// A low gate suspends only the following edge, so its own edge still takes commands
	assign cmd_sel = !pins.cs_n && !susp && !power_down;
	logic is_read, is_write, is_prech, is_bterm, is_active, is_nop;
	assign is_read = cmd_sel && pattern == sdbt_cmd_read;
	assign is_write = cmd_sel && pattern == sdbt_cmd_write;
	assign is_prech = cmd_sel && pattern == sdbt_cmd_prech;
	assign is_bterm = cmd_sel && pattern == sdbt_cmd_bterm;
	assign is_active = cmd_sel && pattern == sdbt_cmd_active;
	assign is_nop = pins.cs_n || pattern == sdbt_cmd_nop;

	sdbt_bank_type bank_st [sdbt_nbanks];
	logic any_access;
	logic all_idle;
	always_comb begin
		any_access = 1'b0;
		all_idle = 1'b1;
		for (int i = 0; i < sdbt_nbanks; i++) begin
			if (bank_st[i] == sdbt_reading || bank_st[i] == sdbt_writing) begin
				any_access = 1'b1;
			end
			if (bank_st[i] != sdbt_idle) begin
				all_idle = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Power-down and clock suspend
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cke_prev <= 1'b1;
		end else begin
			cke_prev <= pins.cke;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down <= 1'b0;
			precharge_power_down <= 1'b0;
		end else if (!power_down && cke_prev && !pins.cke && is_nop && !any_access) begin
			power_down <= 1'b1;
			precharge_power_down <= all_idle;
		end else if (power_down && pins.cke && is_nop) begin
			power_down <= 1'b0;
			precharge_power_down <= 1'b0;
		end
	end

	// Suspend the internal edge following each low-sampled gate during a read or write access, outside power-down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			susp <= 1'b0;
		end else if (!pins.cke && (any_access || susp) && !power_down) begin
			susp <= 1'b1;
		end else if (pins.cke) begin
			susp <= 1'b0;
		end
	end
	assign clock_suspended = susp;

	// ----------------------------------------
	// Burst engine
	// ----------------------------------------
	logic wr_act, rd_act, ap_pend;
	logic [sdbt_bank_bits-1:0] cur_bank;
	logic [sdbt_col_bits-1:0] cur_col;
	logic [sdbt_col_bits:0] remain;
	logic full_page;
	logic [sdbt_col_bits:0] blen;
	logic adv;
	assign adv = !susp && !power_down;
	always_comb begin
		unique case (burst_len_code)
			3'h0: blen = 9'h001;
			3'h1: blen = 9'h002;
			3'h2: blen = 9'h004;
			3'h3: blen = 9'h008;
			default: blen = 9'h100;
		endcase
	end
	assign full_page = burst_len_code == sdbt_burst_full;

	logic [sdbt_bank_bits-1:0] cmd_bank;
	logic [sdbt_col_bits-1:0] cmd_col;
	logic cmd_ap;
	assign cmd_bank = pins.bank;
	assign cmd_col = pins.addr[sdbt_col_bits-1:0];
	assign cmd_ap = pins.addr[sdbt_all_bank_pos];
	logic burst_last;
	assign burst_last = !full_page && remain == 9'h001;
	logic burst_stop;
	assign burst_stop = is_bterm || (is_prech && (pins.addr[sdbt_all_bank_pos] || pins.bank == cur_bank));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_act <= 1'b0;
			rd_act <= 1'b0;
			ap_pend <= 1'b0;
			cur_bank <= '0;
			cur_col <= '0;
			remain <= '0;
		end else if (is_write) begin
			wr_act <= !write_burst_mode_bit && (blen != 9'h001);
			rd_act <= 1'b0;
			ap_pend <= cmd_ap;
			cur_bank <= cmd_bank;
			cur_col <= cmd_col + 8'h01;
			remain <= write_burst_mode_bit ? 9'h000 : blen - 9'h001;
		end else if (is_read) begin
			wr_act <= 1'b0;
			rd_act <= blen != 9'h001;
			ap_pend <= cmd_ap;
			cur_bank <= cmd_bank;
			cur_col <= cmd_col + 8'h01;
			remain <= blen - 9'h001;
		end else if (burst_stop) begin
			wr_act <= 1'b0;
			rd_act <= 1'b0;
			ap_pend <= 1'b0;
		end else if (adv && (wr_act || rd_act)) begin
			cur_col <= cur_col + 8'h01;
			if (!full_page) begin
				remain <= remain - 9'h001;
			end
			// Auto-precharge choice kept so the bank closes after the last word
			if (burst_last) begin
				wr_act <= 1'b0;
				rd_act <= 1'b0;
			end
		end
	end

	// Write port: unmasked command-edge word and each following unmasked word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_valid <= 1'b0;
			wr_bank <= '0;
			wr_col <= '0;
			wr_data <= '0;
		end else begin
			wr_valid <= 1'b0;
			if (is_write) begin
				wr_valid <= !pins.dqm;
				wr_bank <= cmd_bank;
				wr_col <= cmd_col;
				wr_data <= pins.dq_in;
			end else if (wr_act && adv && !is_read && !burst_stop) begin
				wr_valid <= !pins.dqm;
				wr_bank <= cur_bank;
				wr_col <= cur_col;
				wr_data <= pins.dq_in;
			end
		end
	end

	// ----------------------------------------
	// Read data pipeline; held during suspend
	// ----------------------------------------
	logic [2:0] rd_pipe;
	logic dqm_pipe;
	logic rd_word_now;
	logic [3:0] rd_tap;
	// Word leaves the array on the read edge and each unsuspended burst edge
	assign rd_word_now = is_read || (rd_act && adv && !is_write && !burst_stop);
	assign rd_tap = {rd_pipe, rd_word_now};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pipe <= '0;
			dqm_pipe <= 1'b0;
		end else if (!susp) begin
			rd_pipe <= {rd_pipe[1:0], rd_word_now};
			dqm_pipe <= pins.dqm;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins.dq_dev_oe <= 1'b0;
			pins.dq_dev_out <= '0;
		end else if (is_write) begin
			pins.dq_dev_oe <= 1'b0;
		end else if (!susp) begin
			pins.dq_dev_oe <= rd_tap[read_latency_cycles - 2'h1] && !dqm_pipe;
			pins.dq_dev_out <= rd_data;
		end
	end

	// ----------------------------------------
	// Bank states
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < sdbt_nbanks; i++) begin
				bank_st[i] <= sdbt_idle;
			end
		end else begin
			for (int i = 0; i < sdbt_nbanks; i++) begin
				if (is_prech && (pins.addr[sdbt_all_bank_pos] || pins.bank == i[1:0])) begin
					bank_st[i] <= sdbt_idle;
				end else if (is_active && pins.bank == i[1:0] && bank_st[i] == sdbt_idle) begin
					bank_st[i] <= sdbt_row_active;
				end else if ((is_read || is_write) && pins.bank == i[1:0] && bank_st[i] != sdbt_idle) begin
					bank_st[i] <= is_read ? sdbt_reading : sdbt_writing;
				end else if (bank_st[i] inside {sdbt_reading, sdbt_writing} && cur_bank == i[1:0]
					&& !wr_act && !rd_act) begin
					bank_st[i] <= ap_pend ? sdbt_idle : sdbt_row_active;
				end else if (bank_st[i] inside {sdbt_reading, sdbt_writing} && cur_bank != i[1:0]) begin
					bank_st[i] <= sdbt_row_active;
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < sdbt_nbanks; i++) begin
			bank_states[2*i +: 2] = bank_st[i];
		end
	end
endmodule : sdbt_device

// ===== sdbt_ctrl.sv
// Controller end: issues one command per request and keeps precharge/recovery spacing.
// Assumes the user sequences commands; pins are synchronous to ref_clk.
`timescale 1ns/1ps
module sdbt_ctrl import sdbt_pkg::*; (
	input wire logic rst_n,
	sdbt_if.ctrl pins,
	input wire logic req_valid,
	input wire logic [2:0] req_cmd,
	input wire logic [sdbt_bank_bits-1:0] req_bank,
	input wire logic [sdbt_addr_bits-1:0] req_addr,
	input wire logic req_dqm,
	input wire logic req_drive,
	input wire logic [sdbt_data_bits-1:0] req_data,
	input wire logic req_cke,
	output logic req_ready,
	output logic [sdbt_data_bits-1:0] rd_word
);
	wire logic clk = pins.ref_clk;
	logic [3:0] prech_wait;
	logic [3:0] wrec_wait;
	logic [sdbt_data_bits-1:0] dq_s1;

	// Precharge and write recovery spacing
	assign req_ready = prech_wait == 4'h0 && (req_cmd != sdbt_cmd_prech || wrec_wait == 4'h0);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prech_wait <= '0;
			wrec_wait <= '0;
		end else begin
			if (req_valid && req_ready && req_cmd == sdbt_cmd_prech) begin
				prech_wait <= 4'(sdbt_prech_cyc);
			end else if (prech_wait != 4'h0) begin
				prech_wait <= prech_wait - 4'h1;
			end
			if (req_valid && req_ready && req_cmd == sdbt_cmd_write) begin
				wrec_wait <= 4'(sdbt_wrec_cyc);
			end else if (wrec_wait != 4'h0) begin
				wrec_wait <= wrec_wait - 4'h1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins.cke <= 1'b1;
			pins.cs_n <= 1'b1;
			pins.row_strobe_n <= 1'b1;
			pins.col_strobe_n <= 1'b1;
			pins.wr_en_n <= 1'b1;
			pins.addr <= '0;
			pins.bank <= '0;
			pins.dqm <= 1'b0;
			pins.dq_ctl_out <= '0;
			pins.dq_ctl_oe <= 1'b0;
		end else begin
			pins.cke <= req_cke;
			pins.cs_n <= !(req_valid && req_ready);
			{pins.row_strobe_n, pins.col_strobe_n, pins.wr_en_n} <= (req_valid && req_ready) ? req_cmd
				: sdbt_cmd_nop;
			pins.addr <= req_addr;
			pins.bank <= req_bank;
			pins.dqm <= req_dqm;
			pins.dq_ctl_out <= req_data;
			pins.dq_ctl_oe <= req_drive;
		end
	end

	// Read data capture from the shared bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1 <= '0;
			rd_word <= '0;
		end else begin
			dq_s1 <= pins.dq_in;
			rd_word <= dq_s1;
		end
	end
endmodule : sdbt_ctrl

// ===== sdbt_props.sv
// Checker: temporal properties on the link pins and device status outputs.
// Assumes the testbench instantiates it beside the interface; one clock domain.
`timescale 1ns/1ps
module sdbt_props import sdbt_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic wr_en_n,
	input wire logic [sdbt_addr_bits-1:0] addr,
	input wire logic dqm,
	input wire logic dq_dev_oe,
	input wire logic wr_valid,
	input wire logic power_down,
	input wire logic clock_suspended,
	input wire logic [2*sdbt_nbanks-1:0] bank_states
);
	wire logic [2:0] cmd = {row_strobe_n, col_strobe_n, wr_en_n};
	wire logic go = !cs_n && !power_down && !clock_suspended;
	wire logic nop = cs_n || cmd == sdbt_cmd_nop;
	// Upper bit of a bank field set means reading or writing
	wire logic busy = bank_states[1] | bank_states[3] | bank_states[5] | bank_states[7];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_wr_first; go && cmd == sdbt_cmd_write && !dqm |=> wr_valid; endproperty
	a_wr_first: assert property (p_wr_first) else $error("write word not taken with command");
	property p_bterm_ign; go && cmd == sdbt_cmd_bterm |=> !wr_valid; endproperty
	a_bterm_ign: assert property (p_bterm_ign) else $error("data written on terminate edge");
	property p_read_ign; go && cmd == sdbt_cmd_read |=> !wr_valid; endproperty
	a_read_ign: assert property (p_read_ign) else $error("data written on read edge");
	property p_mask_ign; dqm |=> !wr_valid; endproperty
	a_mask_ign: assert property (p_mask_ign) else $error("masked word written");
	property p_prech_all; go && cmd == sdbt_cmd_prech && addr[sdbt_all_bank_pos] |=> bank_states == 8'h00; endproperty
	a_prech_all: assert property (p_prech_all) else $error("banks left open after all-bank close");
	property p_pdn_in; $past(cke) && !cke && nop && !busy && !power_down && !clock_suspended |=> power_down; endproperty
	a_pdn_in: assert property (p_pdn_in) else $error("power-down not entered");
	property p_pdn_hold; power_down && !cke |=> power_down && !dq_dev_oe; endproperty
	a_pdn_hold: assert property (p_pdn_hold) else $error("power-down left or data driven");
	property p_pdn_out; power_down && cke && nop |=> !power_down; endproperty
	a_pdn_out: assert property (p_pdn_out) else $error("power-down not left");
	property p_susp_hold; clock_suspended && !cke |=> !wr_valid; endproperty
	a_susp_hold: assert property (p_susp_hold) else $error("write on suspended edge");
	property p_susp_out; clock_suspended && cke |=> !clock_suspended; endproperty
	a_susp_out: assert property (p_susp_out) else $error("suspend not left");
	c_burst: cover property (wr_valid ##1 wr_valid);
	c_pdn: cover property ($fell(power_down));
	c_susp: cover property ($rose(clock_suspended));
endmodule : sdbt_props

// ===== test_sdram_burst_term_precharge_pwrdn.sv
// Testbench: both link ends joined by the interface, driven through the controller.
// Assumes reset of 12 cycles and a 100 ns clock; dq floats to a cycle count.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_sdram_burst_term_precharge_pwrdn import sdbt_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid, req_dqm, req_drive, req_cke, req_ready, wr_valid, power_down, precharge_power_down;
	logic clock_suspended, wbm;
	logic saw_susp = 1'b0;
	logic [2:0] req_cmd, blen;
	logic [1:0] req_bank, wr_bank;
	logic [10:0] req_addr;
	logic [31:0] req_data, wr_data, rd_word;
	logic [7:0] wr_col, bank_states;
	logic [41:0] got[$];
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int oe_n = 0;
	int rd_n = 0;
	always #50 ref_clk = ~ref_clk;
	sdbt_if sdbt_if_inst(.ref_clk(ref_clk));
	// Undriven bus shows a changing pattern, never the last word
	assign sdbt_if_inst.dq_in = sdbt_if_inst.dq_ctl_oe ? sdbt_if_inst.dq_ctl_out :
		(sdbt_if_inst.dq_dev_oe ? sdbt_if_inst.dq_dev_out : 32'(cyc));
	sdbt_device sdbt_device_inst(.rst_n, .pins(sdbt_if_inst.device), .burst_len_code(blen), .write_burst_mode_bit(wbm),
		.read_latency_cycles(2'h2), .rd_data(32'h5a5a0f0f), .wr_valid, .wr_bank, .wr_col, .wr_data, .power_down,
		.precharge_power_down, .clock_suspended, .bank_states);
	sdbt_ctrl sdbt_ctrl_inst(.rst_n, .pins(sdbt_if_inst.ctrl), .req_valid, .req_cmd, .req_bank, .req_addr, .req_dqm,
		.req_drive, .req_data, .req_cke, .req_ready, .rd_word);
	sdbt_props sdbt_props_inst(.ref_clk, .rst_n, .cke(sdbt_if_inst.cke), .cs_n(sdbt_if_inst.cs_n),
		.row_strobe_n(sdbt_if_inst.row_strobe_n), .col_strobe_n(sdbt_if_inst.col_strobe_n),
		.wr_en_n(sdbt_if_inst.wr_en_n), .addr(sdbt_if_inst.addr), .dqm(sdbt_if_inst.dqm),
		.dq_dev_oe(sdbt_if_inst.dq_dev_oe), .wr_valid, .power_down, .clock_suspended, .bank_states);
	// ------------------------------------------------------------
	// Monitor, timeout and shared tasks
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (wr_valid === 1'b1) got.push_back({wr_bank, wr_col, wr_data});
		if (clock_suspended === 1'b1) saw_susp <= 1'b1;
		if (sdbt_if_inst.dq_dev_oe === 1'b1) oe_n <= oe_n + 1;
		if (rd_word === 32'h5a5a0f0f) rd_n <= rd_n + 1;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Request stays up until the edge that sees ready; next call moves on that edge
	task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a, input logic m,
		input logic [31:0] d, input logic k);
		int n;
		n = 0;
		@(posedge ref_clk);
		#5;
		{req_valid, req_cmd, req_bank, req_addr, req_dqm, req_data, req_cke} = {1'b1, c, b, a, m, d, k};
		req_drive = d != 32'h0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#5;
			n++;
		end
	endtask : op
	task automatic idle(input int n);
		@(posedge ref_clk);
		#5;
		{req_valid, req_drive, req_dqm} = 3'h0;
		repeat (n) @(posedge ref_clk);
		#5;
	endtask : idle
	task automatic chk_w(input logic [1:0] b, input logic [7:0] c, input int n, input logic [31:0] d, input logic last);
		logic [41:0] e;
		for (int k = 0; k < n; k++) begin
			e = (got.size() > 0) ? got.pop_front() : 42'h0;
			`CHK(e, {b, 8'(c + k), d + 32'(k)})
		end
		if (last) `CHK(got.size(), 0)
	endtask : chk_w
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_writes();
		blen = 3'h1;
		op(sdbt_cmd_active, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_write, 2'h1, 11'h005, 1'b0, 32'ha000, 1'b1);
		for (int k = 1; k < 4; k++) op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'ha000 + 32'(k), 1'b1);
		idle(4);
		chk_w(2'h1, 8'h05, 2, 32'ha000, 1'b1);
		blen = 3'h7;
		op(sdbt_cmd_write, 2'h1, 11'h0fe, 1'b0, 32'hb000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'hb001, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'hb002, 1'b1);
		op(sdbt_cmd_bterm, 2'h1, 11'h000, 1'b0, 32'hb0ee, 1'b1);
		idle(3);
		chk_w(2'h1, 8'hfe, 3, 32'hb000, 1'b1);
		blen = 3'h2;
		op(sdbt_cmd_write, 2'h1, 11'h010, 1'b0, 32'hc000, 1'b1);
		op(sdbt_cmd_write, 2'h1, 11'h040, 1'b0, 32'hd000, 1'b1);
		for (int k = 1; k < 5; k++) op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'hd000 + 32'(k), 1'b1);
		idle(3);
		chk_w(2'h1, 8'h10, 1, 32'hc000, 1'b0);
		chk_w(2'h1, 8'h40, 4, 32'hd000, 1'b1);
	endtask : t_writes
	task automatic t_w2r_single();
		op(sdbt_cmd_write, 2'h1, 11'h020, 1'b0, 32'he000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'he001, 1'b1);
		op(sdbt_cmd_read, 2'h1, 11'h000, 1'b0, 32'he002, 1'b1);
		oe_n = 0;
		rd_n = 0;
		idle(10);
		chk_w(2'h1, 8'h20, 2, 32'he000, 1'b1);
		`CHK(oe_n, 4)
		`CHK(rd_n, 4)
		wbm = 1'b1;
		blen = 3'h3;
		op(sdbt_cmd_write, 2'h1, 11'h060, 1'b0, 32'hf000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'hf001, 1'b1);
		op(sdbt_cmd_read, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		oe_n = 0;
		rd_n = 0;
		idle(14);
		chk_w(2'h1, 8'h60, 1, 32'hf000, 1'b1);
		`CHK(oe_n, 8)
		`CHK(rd_n, 8)
		wbm = 1'b0;
	endtask : t_w2r_single
	task automatic t_rd_cut();
		blen = 3'h7;
		op(sdbt_cmd_read, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		oe_n = 0;
		rd_n = 0;
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_bterm, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		idle(8);
		`CHK(oe_n, 3)
		`CHK(rd_n, 3)
		op(sdbt_cmd_read, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		oe_n = 0;
		rd_n = 0;
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_prech, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
		idle(8);
		`CHK(oe_n, 2)
		`CHK(rd_n, 2)
		`CHK(bank_states[3:2], 2'h0)
		op(sdbt_cmd_active, 2'h1, 11'h000, 1'b0, 32'h0, 1'b1);
	endtask : t_rd_cut
	task automatic t_prech();
		op(sdbt_cmd_write, 2'h1, 11'h070, 1'b0, 32'h1000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h1001, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b1, 32'h1002, 1'b1);
		op(sdbt_cmd_prech, 2'h1, 11'h000, 1'b1, 32'h1003, 1'b1);
		idle(3);
		chk_w(2'h1, 8'h70, 2, 32'h1000, 1'b1);
		`CHK(bank_states, 8'h00)
		op(sdbt_cmd_active, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_active, 2'h2, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_prech, 2'h3, 11'h400, 1'b0, 32'h0, 1'b1);
		idle(2);
		`CHK(bank_states, 8'h00)
		op(sdbt_cmd_active, 2'h2, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_active, 2'h3, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_prech, 2'h2, 11'h000, 1'b0, 32'h0, 1'b1);
		idle(2);
		`CHK(bank_states, 8'h40)
		blen = 3'h1;
		op(sdbt_cmd_active, 2'h2, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_write, 2'h2, 11'h400, 1'b0, 32'h3000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h3001, 1'b1);
		idle(3);
		chk_w(2'h2, 8'h00, 2, 32'h3000, 1'b1);
		`CHK(bank_states, 8'h40)
	endtask : t_prech
	task automatic t_pdn();
		for (int k = 0; k < 2; k++) begin
			op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h0, 1'b0);
			idle(3);
			`CHK({power_down, precharge_power_down}, {1'b1, k == 1})
			op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
			op(sdbt_cmd_active, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
			idle(2);
			`CHK({power_down, bank_states[1:0]}, 3'h1)
			op(sdbt_cmd_prech, 2'h0, 11'h400, 1'b0, 32'h0, 1'b1);
			idle(2);
		end
	endtask : t_pdn
	task automatic t_susp();
		blen = 3'h7;
		op(sdbt_cmd_active, 2'h0, 11'h000, 1'b0, 32'h0, 1'b1);
		op(sdbt_cmd_write, 2'h0, 11'h030, 1'b0, 32'h2000, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h2001, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h2002, 1'b0);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h20ee, 1'b0);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h20ef, 1'b1);
		op(sdbt_cmd_nop, 2'h0, 11'h000, 1'b0, 32'h2003, 1'b1);
		op(sdbt_cmd_bterm, 2'h0, 11'h000, 1'b0, 32'h20aa, 1'b1);
		idle(3);
		chk_w(2'h0, 8'h30, 4, 32'h2000, 1'b1);
		`CHK(saw_susp, 1'b1)
	endtask : t_susp
	initial begin
		{req_valid, req_cmd, req_bank, req_addr, req_dqm, req_drive, req_data} = 51'h0;
		{req_cke, blen, wbm} = {1'b1, 3'h1, 1'b0};
		repeat (12) @(posedge ref_clk);
		#5;
		rst_n = 1'b1;
		t_writes();
		t_w2r_single();
		t_rd_cut();
		t_prech();
		t_pdn();
		t_susp();
		end_sim();
	end
endmodule : test_sdram_burst_term_precharge_pwrdn
